// ---- rtl/uefc_fifo_ctl.sv ----
// Notes on behaviour
// R1 - a receive flush returns both receive fifo pointers to reset values
// R2 - host stops the receiver and waits for confirmation before flushing
// R3 - the flush request bit clears itself once the flush is done
// R4 - host clears receiver enable to stop frame reception
// R5 - one pulse on receiver stopped event when receiver really halts
// R6 - host sets receiver enable again to resume reception
// R7 - usb bulk-out words are buffered in an 8 kB transmit fifo
// R8 - errored packet rewinds write pointer to the packet head pointer
// R9 - write side stores data unmodified; frames extracted on read side
// R10 - each buffer starts with command a then command b words
// R11 - command b must match across a frame except checksum bit; else error
// R12 - host puts the same frame length in every command b of a frame
// R13 - command a bits 17:16 give the data start offset, 0 to 3
// R14 - command a bit 13 marks the first segment of a frame
// R15 - command a bit 12 marks the last segment of a frame
// R16 - command a bits 10:0 give payload bytes, no offset or padding
// R17 - trailing padding bytes derived from size and offset are dropped
// R18 - summed buffer sizes are checked against frame length; error if not
// R19 - command b bits 10:0 give the total frame byte count
// R20 - payload starts at the third word of each buffer
// R21 - offset low bits select first valid byte lane, 00 is D[7:0]
// R22 - reserved command a bits are ignored when parsing
module uefc_fifo_ctl
    import uefc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              rx_flush_set,
    input  wire logic              receiver_enable_bit,
    input  wire logic              rx_halted,
    input  wire logic              rx_wr_adv,
    input  wire logic              rx_rd_adv,
    output logic                   rx_flush_busy_q,
    output logic                   receiver_stopped_event_q,
    output logic [RX_PW-1:0]       rx_wr_ptr_q,
    output logic [RX_PW-1:0]       rx_rd_ptr_q,
    input  wire uefc_usb_word_type usb_in,
    input  wire logic              usb_pkt_end,
    input  wire logic              usb_pkt_err,
    output logic                   usb_ready_q,
    output uefc_mac_word_type      mac_q,
    input  wire logic              mac_ready,
    input  wire logic              tx_error_clear,
    output logic                   transmitter_error_flag_q
);

    // ==========================================================
    // receive flush and receiver stop
    logic halted_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_flush_busy_q <= 1'b0;
        end else if (rx_flush_set) begin
            rx_flush_busy_q <= 1'b1;
        end else begin
            rx_flush_busy_q <= 1'b0; // R3
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || rx_flush_busy_q) begin
            rx_wr_ptr_q <= RX_PTR_RESET; // R1
            rx_rd_ptr_q <= RX_PTR_RESET; // R1
        end else begin
            if (rx_wr_adv) begin
                rx_wr_ptr_q <= rx_wr_ptr_q + 1'b1;
            end
            if (rx_rd_adv) begin
                rx_rd_ptr_q <= rx_rd_ptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            halted_q                 <= 1'b0;
            receiver_stopped_event_q <= 1'b0;
        end else begin
            halted_q                 <= rx_halted;
            receiver_stopped_event_q <= rx_halted && !halted_q &&
                                        !receiver_enable_bit; // R5
        end
    end

    // ==========================================================
    // transmit fifo write side
    logic [31:0]      tx_mem [TX_WORDS];
    logic [TX_PW-1:0] tx_wr_ptr_q, tx_rd_ptr_q;
    logic [TX_PW-1:0] tx_write_head_pointer_q;
    logic             wr_take;
    logic [TX_PW-1:0] tx_count;

    assign wr_take  = usb_in.valid && usb_ready_q;
    assign tx_count = tx_wr_ptr_q - tx_rd_ptr_q;

    always_ff @(posedge clk) begin
        if (wr_take && !usb_pkt_err) begin
            tx_mem[tx_wr_ptr_q[TX_AW-1:0]] <= usb_in.data; // R7 R9
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_wr_ptr_q             <= TX_PTR_RESET;
            tx_write_head_pointer_q <= TX_PTR_RESET;
        end else if (usb_pkt_err) begin
            tx_wr_ptr_q <= tx_write_head_pointer_q; // R8
        end else begin
            if (wr_take) begin
                tx_wr_ptr_q <= tx_wr_ptr_q + 1'b1;
            end
            if (usb_pkt_end) begin
                tx_write_head_pointer_q <= tx_wr_ptr_q +
                                           TX_PW'(wr_take); // R8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            usb_ready_q <= 1'b0;
        end else begin
            usb_ready_q <= tx_count < TX_READY_LIMIT; // R7
        end
    end

    // ==========================================================
    // transmit fifo read side: command parse and frame extraction
    uefc_state_type state_q;
    logic [31:0]    rd_word;
    logic           avail, out_free, take;
    logic [31:0]    cmda_q, cmdb_q;
    logic [11:0]    acc_q;
    logic [10:0]    rem_q, words_q;
    logic [1:0]     lane_q;
    logic           ls_q;
    logic [1:0]     a_off;
    logic [10:0]    a_size;
    logic           a_fs;
    logic [11:0]    new_acc;
    logic [10:0]    new_words;
    logic           cmdb_bad, len_bad;
    logic [2:0]     room, nbytes;

    function automatic logic [3:0] lane_mask(input logic [1:0] lane,
                                             input logic [2:0] n);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (3'(i) >= {1'b0, lane}) && (3'(i) < {1'b0, lane} + n);
        end
        return m;
    endfunction

    assign rd_word  = tx_mem[tx_rd_ptr_q[TX_AW-1:0]];
    assign avail    = tx_rd_ptr_q != tx_write_head_pointer_q;
    assign out_free = !mac_q.valid || mac_ready;
    assign take     = (state_q == S_DATA) && avail && out_free;

    // reserved bits of command a never reach any decision
    assign a_off     = cmda_q[CMDA_OFF_HI:CMDA_OFF_LO]; // R13 R22
    assign a_size    = cmda_q[CMDA_SIZE_HI:0]; // R16
    assign a_fs      = cmda_q[CMDA_FS_BIT]; // R14
    assign new_acc   = a_fs ? {1'b0, a_size}
                            : acc_q + {1'b0, a_size}; // R18
    assign new_words = (a_size == 11'h000) ? 11'h000 :
                       11'((13'(a_size) + 13'(a_off) + 13'h0003) >> 2);
    assign cmdb_bad  = !a_fs &&
                       ((rd_word & CMDB_CMP_MASK) !=
                        (cmdb_q & CMDB_CMP_MASK)); // R11
    assign len_bad   = (new_acc > {1'b0, rd_word[CMDB_FLEN_HI:0]}) ||
                       (cmda_q[CMDA_LS_BIT] &&
                        new_acc != {1'b0, rd_word[CMDB_FLEN_HI:0]}); // R18
    assign room      = 3'h4 - {1'b0, lane_q};
    assign nbytes    = (rem_q < 11'(room)) ? rem_q[2:0] : room; // R17

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q     <= S_CMDA;
            tx_rd_ptr_q <= TX_PTR_RESET;
            cmda_q      <= 32'h0000_0000;
            cmdb_q      <= 32'h0000_0000;
            acc_q       <= 12'h000;
            rem_q       <= 11'h000;
            words_q     <= 11'h000;
            lane_q      <= 2'h0;
            ls_q        <= 1'b0;
        end else begin
            unique case (state_q)
                S_CMDA: begin
                    if (avail) begin
                        cmda_q      <= rd_word; // R10
                        tx_rd_ptr_q <= tx_rd_ptr_q + 1'b1;
                        state_q     <= S_CMDB;
                    end
                end
                S_CMDB: begin
                    if (avail) begin
                        cmdb_q      <= rd_word; // R10 R19
                        acc_q       <= new_acc; // R18
                        rem_q       <= a_size;
                        words_q     <= new_words; // R17
                        lane_q      <= a_off; // R21
                        ls_q        <= cmda_q[CMDA_LS_BIT]; // R15
                        tx_rd_ptr_q <= tx_rd_ptr_q + 1'b1;
                        state_q     <= (new_words == 11'h000) ? S_CMDA
                                                              : S_DATA; // R20
                    end
                end
                S_DATA: begin
                    if (take) begin
                        tx_rd_ptr_q <= tx_rd_ptr_q + 1'b1;
                        rem_q       <= rem_q - 11'(nbytes);
                        words_q     <= words_q - 1'b1;
                        lane_q      <= 2'h0;
                        if (words_q == 11'h001) begin
                            state_q <= S_CMDA;
                        end
                    end
                end
                default: begin
                    state_q <= S_CMDA;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mac_q <= '0;
        end else if (take) begin
            mac_q.valid   <= 1'b1;
            mac_q.data    <= rd_word;
            mac_q.byte_en <= lane_mask(lane_q, nbytes); // R17 R21
            mac_q.last    <= ls_q && (words_q == 11'h001); // R15
        end else if (mac_ready) begin
            mac_q.valid <= 1'b0;
        end
    end

    // ==========================================================
    // transmitter error flag: a new error wins over a clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            transmitter_error_flag_q <= 1'b0;
        end else if (state_q == S_CMDB && avail && (cmdb_bad || len_bad)) begin
            transmitter_error_flag_q <= 1'b1; // R11 R18
        end else if (tx_error_clear) begin
            transmitter_error_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    flush_ptr_a: assert property (@(posedge clk) disable iff (!resetn) // R1
        rx_flush_busy_q |=> rx_wr_ptr_q == RX_PTR_RESET &&
                            rx_rd_ptr_q == RX_PTR_RESET)
        else $error("rx pointers not reset by flush");
    flush_clear_a: assert property (@(posedge clk) disable iff (!resetn) // R3
        rx_flush_set ##1 !rx_flush_set |=> !rx_flush_busy_q)
        else $error("flush bit did not clear");
    stop_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R5
        receiver_stopped_event_q |-> !$past(receiver_enable_bit) ##1
                                     !receiver_stopped_event_q)
        else $error("stop event not a single pulse");
    wr_rewind_a: assert property (@(posedge clk) disable iff (!resetn) // R8
        usb_pkt_err |=> tx_wr_ptr_q == $past(tx_write_head_pointer_q))
        else $error("write pointer not rewound to head");
    cmd_order_a: assert property (@(posedge clk) disable iff (!resetn) // R10
        state_q == S_CMDA && avail |=>
            state_q == S_CMDB &&
            tx_rd_ptr_q == $past(tx_rd_ptr_q) + 12'h001)
        else $error("command b does not follow command a");
    cmdb_match_a: assert property (@(posedge clk) disable iff (!resetn) // R11
        state_q == S_CMDB && avail && cmdb_bad |=> transmitter_error_flag_q)
        else $error("command b mismatch not flagged");
    len_check_a: assert property (@(posedge clk) disable iff (!resetn) // R18
        state_q == S_CMDB && avail && len_bad |=> transmitter_error_flag_q)
        else $error("frame length mismatch not flagged");
    first_lane_a: assert property (@(posedge clk) disable iff (!resetn) // R21
        take && lane_q != 2'h0 |=> !mac_q.byte_en[0])
        else $error("first byte lane ignores offset");
    no_pad_a: assert property (@(posedge clk) disable iff (!resetn) // R17
        mac_q.valid |-> mac_q.byte_en != 4'h0)
        else $error("padding word forwarded");
    flush_c: cover property (@(posedge clk) disable iff (!resetn)
        rx_flush_set ##1 rx_flush_busy_q ##1 !rx_flush_busy_q);
    rewind_c: cover property (@(posedge clk) disable iff (!resetn)
        wr_take ##1 usb_pkt_err);
    frame_end_c: cover property (@(posedge clk) disable iff (!resetn)
        mac_q.valid && mac_q.last && mac_ready);
    error_c: cover property (@(posedge clk) disable iff (!resetn)
        $rose(transmitter_error_flag_q));

endmodule

// ---- pkg/uefc_pkg.sv ----
package uefc_pkg;

    // ==========================================================
    // tx fifo geometry
    localparam int TX_FIFO_BYTES = 8192;
    localparam int TX_WORDS      = TX_FIFO_BYTES / 4;
    localparam int TX_AW         = $clog2(TX_WORDS);
    localparam int TX_PW         = TX_AW + 1;
    localparam logic [TX_PW-1:0] TX_PTR_RESET = 12'h000;
    localparam logic [TX_PW-1:0] TX_READY_LIMIT = TX_PW'(TX_WORDS - 1);

    // ==========================================================
    // rx fifo pointers
    localparam int RX_PW = 12;
    localparam logic [RX_PW-1:0] RX_PTR_RESET = 12'h000;

    // ==========================================================
    // command a fields
    localparam int CMDA_OFF_HI  = 17;
    localparam int CMDA_OFF_LO  = 16;
    localparam int CMDA_FS_BIT  = 13;
    localparam int CMDA_LS_BIT  = 12;
    localparam int CMDA_SIZE_HI = 10;

    // ==========================================================
    // command b fields
    localparam int CMDB_FLEN_HI = 10;
    localparam logic [31:0] CMDB_CMP_MASK = 32'hFFFF_BFFF;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } uefc_usb_word_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic [3:0]  byte_en;
        logic        last;
    } uefc_mac_word_type;

    typedef enum logic [1:0] {
        S_CMDA = 2'b00,
        S_CMDB = 2'b01,
        S_DATA = 2'b10
    } uefc_state_type;

endpackage

// ---- testbench/uefc_mac_sink.sv ----
module uefc_mac_sink
    import uefc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire uefc_mac_word_type mac_q,
    output logic                   mac_ready,
    output uefc_mac_word_type      cap_q
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] stall_q;

    // ==========================================================
    // ready drops one cycle in three so mac_q must hold
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stall_q <= 2'h0;
        end else begin
            stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
        end
    end
    assign mac_ready = (stall_q != 2'h2);

    // ==========================================================
    // each accepted word shows on cap_q for one cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cap_q <= '0;
        end else begin
            cap_q       <= mac_q;
            cap_q.valid <= mac_q.valid && mac_ready;
        end
    end
endmodule

// ---- testbench/usb_eth_fifo_ctl_rx_flush_tx_cmd_tb_top.sv ----
module usb_eth_fifo_ctl_rx_flush_tx_cmd_tb_top;
    import uefc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [1:0]  off;
        logic [10:0] size;
        logic [3:0]  be_first;
        logic [3:0]  be_last;
        logic [3:0]  words;
    } uefc_row_type;

    localparam uefc_row_type ROWS [4] = '{
        '{2'h0, 11'h004, 4'hf, 4'hf, 4'h1},
        '{2'h1, 11'h005, 4'he, 4'h3, 4'h2},
        '{2'h3, 11'h001, 4'h8, 4'h8, 4'h1},
        '{2'h2, 11'h006, 4'hc, 4'hf, 4'h2}};

    logic clk, resetn, rx_flush_set, receiver_enable_bit, rx_halted;
    logic rx_wr_adv, rx_rd_adv, rx_flush_busy_q, receiver_stopped_event_q;
    logic usb_pkt_end, usb_pkt_err, usb_ready_q, mac_ready;
    logic tx_error_clear, transmitter_error_flag_q;
    logic [RX_PW-1:0]  rx_wr_ptr_q, rx_rd_ptr_q;
    uefc_usb_word_type usb_in;
    uefc_mac_word_type mac_q, cap_q;
    logic [31:0]       a, base;
    logic [3:0]        be;
    int                mismatches, total_checks;

    uefc_fifo_ctl dut (.clk(clk), .resetn(resetn),
        .rx_flush_set(rx_flush_set), .receiver_enable_bit(receiver_enable_bit),
        .rx_halted(rx_halted), .rx_wr_adv(rx_wr_adv), .rx_rd_adv(rx_rd_adv),
        .rx_flush_busy_q(rx_flush_busy_q),
        .receiver_stopped_event_q(receiver_stopped_event_q),
        .rx_wr_ptr_q(rx_wr_ptr_q), .rx_rd_ptr_q(rx_rd_ptr_q),
        .usb_in(usb_in), .usb_pkt_end(usb_pkt_end), .usb_pkt_err(usb_pkt_err),
        .usb_ready_q(usb_ready_q), .mac_q(mac_q), .mac_ready(mac_ready),
        .tx_error_clear(tx_error_clear),
        .transmitter_error_flag_q(transmitter_error_flag_q));

    uefc_mac_sink sink (.clk(clk), .resetn(resetn), .mac_q(mac_q),
        .mac_ready(mac_ready), .cap_q(cap_q));

    // ==========================================================
    // checking and closing
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang();
        mismatches++;
        results();
    endtask

    // ==========================================================
    // usb side and mac side transfers
    function automatic logic [31:0] cmda(logic [1:0] off, logic fs, logic ls,
                                         logic [10:0] size);
        return {14'h0, off, 2'h0, fs, ls, 1'b0, size};
    endfunction

    task automatic put(input logic [31:0] w, input logic fin);
        int n = 0;
        while (usb_ready_q !== 1'b1) begin
            usb_in.valid = 1'b0;
            @(negedge clk);
            n++;
            if (n > 100) hang();
        end
        usb_in = '{1'b1, w};
        usb_pkt_end = fin;
        @(negedge clk);
    endtask

    task automatic idle();
        usb_in = '0;
        usb_pkt_end = 1'b0;
        @(negedge clk);
    endtask

    task automatic send_buf(input logic [31:0] ca, input logic [31:0] cb,
                            input int nw, input logic [31:0] b0,
                            input logic fin);
        put(ca, 1'b0);
        put(cb, 1'b0);
        for (int i = 0; i < nw; i++) begin
            put(b0 + 32'(i), fin && (i == nw - 1));
        end
        idle();
    endtask

    task automatic get(input logic [31:0] d, input logic [3:0] e,
                       input logic l);
        int n = 0;
        while (cap_q.valid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 200) hang();
        end
        chk(cap_q.data, d);
        chk(32'(cap_q.byte_en), 32'(e));
        chk(32'(cap_q.last), 32'(l));
        @(negedge clk);
    endtask

    task automatic wait_flag();
        for (int n = 0; n < 60 && transmitter_error_flag_q !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk(32'(transmitter_error_flag_q), 32'h1);
        repeat (10) @(negedge clk);
        tx_error_clear = 1'b1;
        @(negedge clk);
        tx_error_clear = 1'b0;
        @(negedge clk);
        chk(32'(transmitter_error_flag_q), 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // main sequence
    initial begin
        {resetn, rx_flush_set, rx_halted, rx_wr_adv, rx_rd_adv} = '0;
        {usb_pkt_end, usb_pkt_err, tx_error_clear} = '0;
        usb_in = '0;
        receiver_enable_bit = 1'b1;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(negedge clk);
        chk(32'({rx_wr_ptr_q, rx_rd_ptr_q}), 32'h0);
        chk(32'({usb_ready_q, transmitter_error_flag_q, mac_q.valid}), 32'h0);
        resetn = 1'b1;
        for (int r = 0; r < 4; r++) begin
            a = cmda(ROWS[r].off, 1'b1, 1'b1, ROWS[r].size);
            if (r % 2 == 1) a = a | 32'hFFFC_C800;
            base = {8'h5a, 8'(r), 16'h0};
            send_buf(a, {21'h0, ROWS[r].size}, ROWS[r].words, base, 1'b1);
            for (int i = 0; i < ROWS[r].words; i++) begin
                be = (i == 0) ? ROWS[r].be_first : ROWS[r].be_last;
                get(base + 32'(i), be, i == ROWS[r].words - 1);
            end
        end
        chk(32'(transmitter_error_flag_q), 32'h0);
        // two buffers of one frame, checksum bit differs only
        send_buf(cmda(2'h0, 1'b1, 1'b0, 11'h004), 32'h0000_4008, 1,
                 32'h1111_0000, 1'b0);
        send_buf(cmda(2'h0, 1'b0, 1'b1, 11'h004), 32'h0000_0008, 1,
                 32'h2222_0000, 1'b1);
        get(32'h1111_0000, 4'hf, 1'b0);
        get(32'h2222_0000, 4'hf, 1'b1);
        chk(32'(transmitter_error_flag_q), 32'h0);
        // command b differs in another bit
        send_buf(cmda(2'h0, 1'b1, 1'b0, 11'h004), 32'h0000_0008, 1, 0, 1'b0);
        send_buf(cmda(2'h0, 1'b0, 1'b1, 11'h004), 32'h0000_2008, 1, 0, 1'b1);
        wait_flag();
        send_buf(cmda(2'h0, 1'b1, 1'b1, 11'h004), 32'h0000_0005, 1, 0, 1'b1);
        wait_flag();
        // errored packet is overwritten by its retry
        send_buf(cmda(2'h0, 1'b1, 1'b1, 11'h004), 32'h4, 1, 32'hdead_0000, 0);
        usb_pkt_err = 1'b1;
        @(negedge clk);
        usb_pkt_err = 1'b0;
        send_buf(cmda(2'h0, 1'b1, 1'b1, 11'h004), 32'h4, 1, 32'h1234_5678, 1);
        get(32'h1234_5678, 4'hf, 1'b1);
        // receive pointers, stop and flush
        rx_wr_adv = 1'b1;
        rx_rd_adv = 1'b1;
        @(negedge clk);
        rx_rd_adv = 1'b0;
        repeat (2) @(negedge clk);
        rx_wr_adv = 1'b0;
        chk(32'({rx_wr_ptr_q, rx_rd_ptr_q}), 32'h0000_3001);
        receiver_enable_bit = 1'b0;
        rx_halted = 1'b1;
        @(negedge clk);
        chk(32'(receiver_stopped_event_q), 32'h1);
        @(negedge clk);
        chk(32'(receiver_stopped_event_q), 32'h0);
        rx_flush_set = 1'b1;
        @(negedge clk);
        rx_flush_set = 1'b0;
        chk(32'(rx_flush_busy_q), 32'h1);
        @(negedge clk);
        chk(32'(rx_flush_busy_q), 32'h0);
        chk(32'({rx_wr_ptr_q, rx_rd_ptr_q}), 32'h0);
        receiver_enable_bit = 1'b1;
        rx_halted = 1'b0;
        @(negedge clk);
        rx_halted = 1'b1;
        repeat (2) begin
            @(negedge clk);
            chk(32'(receiver_stopped_event_q), 32'h0);
        end
        // reset in mid-run returns the receive pointers to zero
        rx_wr_adv = 1'b1;
        @(negedge clk);
        rx_wr_adv = 1'b0;
        chk(32'(rx_wr_ptr_q), 32'h1);
        resetn = 1'b0;
        @(negedge clk);
        chk(32'({rx_wr_ptr_q, rx_rd_ptr_q}), 32'h0);
        chk(32'({transmitter_error_flag_q, mac_q.valid}), 32'h0);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        results();
    end
endmodule
